// [hdl/lbc_ctrl_if.sv]
// Purpose: carries the decoded control pin events from the pin monitor to the sequencer
// Assumes: one clock domain
// Notes:   en_req is a one-cycle pulse, off_req and duty are levels
`timescale 1ns/1ps
interface lbc_ctrl_if;
	logic       en_req;
	logic       off_req;
	logic [8:0] duty;
	modport mon (output en_req, output off_req, output duty);
	modport seq (input en_req, input off_req, input duty);
endinterface

// [hdl/lbc_ctrl_mon.sv]
// Purpose: synchronises the control pin, finds enable edges, long lows and the dimming duty
// Assumes: pin is asynchronous to clk_sys_i
// Notes:   duty is averaged over a fixed window, so it trails a duty change by one window
`timescale 1ns/1ps
`include "lbc_defines.svh"
module lbc_ctrl_mon #(
	parameter int unsigned OFF_CYC = `LBC_OFF_CYC
) (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	input  wire logic ctrl_pin_i,
	lbc_ctrl_if.mon   ev
);
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        prev;
		logic [16:0] low_cnt;
		logic        off_req;
		logic        en_req;
		logic [11:0] win_cnt;
		logic [12:0] hi_cnt;
		logic [8:0]  duty;
	} lbc_mon_st_t;

	localparam logic [16:0] OFF_CNT = 17'(OFF_CYC);
	localparam logic [11:0] WIN_END = 12'(`LBC_DUTY_WIN - 1);

	lbc_mon_st_t st_r;
	lbc_mon_st_t st_nxt;

	// next state: edge, long-low timer and duty window
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = ctrl_pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		st_nxt.en_req = st_r.s2 & ~st_r.prev;
		// any high sample restarts the timer, so short lows never reach it
		if (st_r.s2)
		begin
			st_nxt.low_cnt = '0;
			st_nxt.off_req = 1'b0;
		end
		else if (st_r.low_cnt == OFF_CNT)
		begin
			st_nxt.off_req = 1'b1;
		end
		else
		begin
			st_nxt.low_cnt = st_r.low_cnt + 17'h0_001;
		end
		st_nxt.win_cnt = st_r.win_cnt + 12'h0_001;
		if (st_r.win_cnt == WIN_END)
		begin
			st_nxt.duty = 9'((st_r.hi_cnt + 13'(st_r.s2)) >> `LBC_DUTY_SHIFT);
			st_nxt.hi_cnt = '0;
		end
		else
		begin
			st_nxt.hi_cnt = st_r.hi_cnt + 13'(st_r.s2);
		end
	end

	// state register; duty starts at full scale
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			st_r <= '{duty: 9'(`LBC_DUTY_FULL), default: '0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign ev.en_req = st_r.en_req;
	assign ev.off_req = st_r.off_req;
	assign ev.duty = st_r.duty;

	property p_long_low;
		@(posedge clk_sys_i) disable iff (reset_i)
		(!st_r.s2 && st_r.low_cnt == OFF_CNT) |=> st_r.off_req;
	endproperty
	a_long_low: assert property (p_long_low) else $error("long low did not raise off request");

	property p_high_clears;
		@(posedge clk_sys_i) disable iff (reset_i)
		st_r.s2 |=> (!st_r.off_req && st_r.low_cnt == 17'h0_0000);
	endproperty
	a_high_clears: assert property (p_high_clears) else $error("high pin left off request set");
endmodule

// [hdl/lbc_defines.svh]
// Purpose: timing counts, reset values and fixed figures of the LED boost sequencer
// Assumes: 50 MHz system clock; the switching clock is a divided enable
// Notes:   the divide, max-on, step, half-limit and off counts are derived here from their times and the clock rate
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

`define LBC_CLK_KHZ      50000
`define LBC_CLK_NS       20
`define LBC_SW_KHZ       1200
// nearest whole divide; 42 gives 1.19 MHz
`define LBC_SW_DIV       ((`LBC_CLK_KHZ + `LBC_SW_KHZ / 2) / `LBC_SW_KHZ)
`define LBC_SW_NS        (`LBC_SW_DIV * `LBC_CLK_NS)
`define LBC_DMAX_PCT     93
`define LBC_MAX_ON       ((`LBC_SW_DIV * `LBC_DMAX_PCT) / 100)
`define LBC_SS_STEPS     32
`define LBC_SS_STEP_US   213
`define LBC_SS_STEP_CYC  ((`LBC_SS_STEP_US * 1000 + `LBC_SW_NS - 1) / `LBC_SW_NS)
`define LBC_HALF_MS      5
`define LBC_HALF_CYC     ((`LBC_HALF_MS * 1000000 + `LBC_SW_NS - 1) / `LBC_SW_NS)
`define LBC_T_OFF_US     2500
`define LBC_OFF_CYC      ((`LBC_T_OFF_US * 1000 + `LBC_CLK_NS - 1) / `LBC_CLK_NS)
`define LBC_OL_DEBOUNCE  8
`define LBC_REF_FULL_MV  200
`define LBC_DUTY_WIN     4096
`define LBC_DUTY_FULL    256
`define LBC_DUTY_SHIFT   4
`define LBC_PROD_SHIFT   13

`endif

// [hdl/lbc_pkg.sv]
// Purpose: shared types of the LED boost sequencer
// Assumes: nothing
// Notes:   timing figures live in lbc_defines.svh
package lbc_pkg;
	typedef enum logic [1:0] {LBC_SHUT, LBC_RUN, LBC_HOLD, LBC_FAULT} lbc_mode_t;
endpackage

// [hdl/lbc_seq.sv]
// Purpose: enable, soft start, start-up current limit, open-LED latch and PWM gate of the boost
// Assumes: comparator inputs are asynchronous and pass two flip-flops first
// Notes:   reference is in mV with 1 mV resolution, so dimmed values truncate downward
`timescale 1ns/1ps
`include "lbc_defines.svh"
// Function
// - after enable, reference climbs from zero in 32 steps of 213 us each
// - half current limit for the first 5 ms after start
// - overvoltage and feedback-low for 8 switching cycles latch shutdown
// - feedback-low threshold is half the reference in force, dimmed included
// - after open-LED shutdown stay off until the pin goes low then high
// - undervoltage holds shutdown with the switch off
// - over-temperature turns off; clearing resumes by itself
// - pin low longer than 2.5 ms shuts down; shorter lows ignored
// - in shutdown the switch stays off and no pulses occur
// - while active, one PWM switch pulse starts every 1.2 MHz cycle
// - finished ramp reaches a 200 mV reference
// - pin rising edge while shut down enables the device
// - reference is scaled by the measured duty of the control pin
// - step duration counted in switching clock cycles
module lbc_seq #(
	parameter int unsigned OFF_CYC  = `LBC_OFF_CYC,
	parameter int unsigned HALF_CYC = `LBC_HALF_CYC
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic       ctrl_pin_i,
	input  wire logic       sw_ovp_i,
	input  wire logic       fb_low_i,
	input  wire logic       uvlo_i,
	input  wire logic       over_temp_i,
	input  wire logic       cur_trip_i,
	output logic            switch_gate_o,
	output logic [7:0]      ref_mv_o,
	output logic [7:0]      fb_low_thresh_mv_o,
	output logic            ilim_half_o,
	output logic            active_o,
	output logic            open_led_fault_o
);
	// comparator sync bits: 4 ovp, 3 fb low, 2 uvlo, 1 over temp, 0 current trip
	typedef struct packed {
		logic [4:0]        sync1;
		logic [4:0]        sync2;
		lbc_pkg::lbc_mode_t mode;
		logic [5:0]        div;
		logic [5:0]        on_cnt;
		logic [5:0]        step;
		logic [8:0]        step_cnt;
		logic [12:0]       half_cnt;
		logic [2:0]        ol_cnt;
		logic              gate;
		logic [7:0]        ref_mv;
		logic [7:0]        thresh;
		logic              ilim_half;
		logic              active;
		logic              fault;
	} lbc_seq_st_t;

	localparam logic [5:0]  DIV_END  = 6'(`LBC_SW_DIV - 1);
	localparam logic [5:0]  MAX_ON   = 6'(`LBC_MAX_ON);
	localparam logic [5:0]  SS_STEPS = 6'(`LBC_SS_STEPS);
	localparam logic [8:0]  STEP_END = 9'(`LBC_SS_STEP_CYC - 1);
	localparam logic [12:0] HALF_END = 13'(HALF_CYC);
	localparam logic [2:0]  OL_LAST  = 3'(`LBC_OL_DEBOUNCE - 1);

	lbc_ctrl_if  ctrl ();
	lbc_seq_st_t st_r;
	lbc_seq_st_t st_nxt;
	logic        tick;
	logic        ovp_s;
	logic        fbl_s;
	logic        uv_s;
	logic        ot_s;
	logic        trip_s;
	logic        ol_hit;
	logic [21:0] prod;

	lbc_ctrl_mon #(
		.OFF_CYC (OFF_CYC)
	) u_mon (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.ctrl_pin_i (ctrl_pin_i),
		.ev         (ctrl.mon)
	);

	// only the second sync stage is read by logic
	assign ovp_s = st_r.sync2[4];
	assign fbl_s = st_r.sync2[3];
	assign uv_s = st_r.sync2[2];
	assign ot_s = st_r.sync2[1];
	assign trip_s = st_r.sync2[0];
	assign tick = (st_r.div == DIV_END);
	assign ol_hit = ovp_s & fbl_s;
	// full scale times step fraction times duty fraction
	assign prod = 22'(`LBC_REF_FULL_MV) * 22'(st_r.step) * 22'(ctrl.duty);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sync1 = {sw_ovp_i, fb_low_i, uvlo_i, over_temp_i, cur_trip_i};
		st_nxt.sync2 = st_r.sync1;
		// free-running divider: the switching clock is an enable
		st_nxt.div = tick ? 6'h00 : st_r.div + 6'h01;
		unique case (st_r.mode)
			lbc_pkg::LBC_SHUT:
			begin
				if (ctrl.en_req)
				begin
					st_nxt.mode = (uv_s | ot_s) ? lbc_pkg::LBC_HOLD : lbc_pkg::LBC_RUN;
				end
			end
			lbc_pkg::LBC_RUN:
			begin
				if (ctrl.off_req)
				begin
					st_nxt.mode = lbc_pkg::LBC_SHUT;
				end
				else if (uv_s | ot_s)
				begin
					st_nxt.mode = lbc_pkg::LBC_HOLD;
				end
				else if (tick)
				begin
					// debounce sampled once per switching cycle
					if (!ol_hit)
					begin
						st_nxt.ol_cnt = 3'h0;
					end
					else if (st_r.ol_cnt == OL_LAST)
					begin
						st_nxt.mode = lbc_pkg::LBC_FAULT;
					end
					else
					begin
						st_nxt.ol_cnt = st_r.ol_cnt + 3'h1;
					end
					if (st_r.step != SS_STEPS)
					begin
						st_nxt.step_cnt = (st_r.step_cnt == STEP_END) ? 9'h000 : st_r.step_cnt + 9'h001;
						if (st_r.step_cnt == STEP_END)
						begin
							st_nxt.step = st_r.step + 6'h01;
						end
					end
					if (st_r.half_cnt != HALF_END)
					begin
						st_nxt.half_cnt = st_r.half_cnt + 13'h0001;
					end
				end
			end
			lbc_pkg::LBC_HOLD:
			begin
				// a long low still wins, so a host that gave up is not restarted
				if (ctrl.off_req)
				begin
					st_nxt.mode = lbc_pkg::LBC_SHUT;
				end
				else if (!uv_s && !ot_s)
				begin
					st_nxt.mode = lbc_pkg::LBC_RUN;
				end
			end
			lbc_pkg::LBC_FAULT:
			begin
				// only a fresh rising edge leaves the latch
				if (ctrl.en_req)
				begin
					st_nxt.mode = (uv_s | ot_s) ? lbc_pkg::LBC_HOLD : lbc_pkg::LBC_RUN;
				end
			end
		endcase
		// any entry into run restarts the start-up sequence
		if (st_nxt.mode == lbc_pkg::LBC_RUN && st_r.mode != lbc_pkg::LBC_RUN)
		begin
			st_nxt.ol_cnt = 3'h0;
			st_nxt.step = 6'h00;
			st_nxt.step_cnt = 9'h000;
			st_nxt.half_cnt = 13'h0000;
		end
		// gate: on at each cycle start, off on current trip or max duty
		if (st_nxt.mode != lbc_pkg::LBC_RUN)
		begin
			st_nxt.gate = 1'b0;
			st_nxt.on_cnt = 6'h00;
		end
		else if (tick)
		begin
			st_nxt.gate = 1'b1;
			st_nxt.on_cnt = 6'h00;
		end
		else
		begin
			st_nxt.on_cnt = st_r.on_cnt + 6'h01;
			// on_cnt is 0 in the first on cycle, so MAX_ON - 1 is the last one allowed
			if (trip_s || st_r.on_cnt == MAX_ON - 6'h01)
			begin
				st_nxt.gate = 1'b0;
			end
		end
		st_nxt.ref_mv = (st_r.mode == lbc_pkg::LBC_RUN) ? prod[20:13] : 8'h00;
		st_nxt.thresh = st_nxt.ref_mv >> 1;
		st_nxt.ilim_half = (st_nxt.mode == lbc_pkg::LBC_RUN) && (st_nxt.half_cnt != HALF_END);
		// status outputs registered so no decode glitch reaches the pins
		st_nxt.active = (st_nxt.mode == lbc_pkg::LBC_RUN);
		st_nxt.fault = (st_nxt.mode == lbc_pkg::LBC_FAULT);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			st_r <= '{mode: lbc_pkg::LBC_SHUT, default: '0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign switch_gate_o = st_r.gate;
	assign ref_mv_o = st_r.ref_mv;
	assign fb_low_thresh_mv_o = st_r.thresh;
	assign ilim_half_o = st_r.ilim_half;
	assign active_o = st_r.active;
	assign open_led_fault_o = st_r.fault;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	property p_step_up;
		(active_o && tick && st_r.step != SS_STEPS && st_r.step_cnt == STEP_END && st_nxt.mode == lbc_pkg::LBC_RUN)
		|=> st_r.step == $past(st_r.step) + 6'h01;
	endproperty
	a_step_up: assert property (p_step_up) else $error("ramp step missed");

	property p_step_timed;
		(active_o && !tick) |=> $stable(st_r.step_cnt) || !active_o;
	endproperty
	a_step_timed: assert property (p_step_timed) else $error("step counter moved off tick");

	property p_full_ref;
		(active_o && st_r.step == SS_STEPS && ctrl.duty == 9'(`LBC_DUTY_FULL)) |=> ref_mv_o == 8'hc8;
	endproperty
	a_full_ref: assert property (p_full_ref) else $error("final reference not 200 mV");

	property p_thresh;
		fb_low_thresh_mv_o == (ref_mv_o >> 1);
	endproperty
	a_thresh: assert property (p_thresh) else $error("feedback-low threshold not half reference");

	property p_half_start;
		(!active_o ##1 active_o) |-> ilim_half_o && st_r.step == 6'h00 && st_r.ol_cnt == 3'h0;
	endproperty
	a_half_start: assert property (p_half_start) else $error("restart did not reset start-up");

	property p_ol_trip;
		(active_o && tick && ol_hit && st_r.ol_cnt == OL_LAST && !ctrl.off_req && !uv_s && !ot_s)
		|=> open_led_fault_o && !switch_gate_o;
	endproperty
	a_ol_trip: assert property (p_ol_trip) else $error("open LED did not latch");

	property p_ol_clear;
		(active_o && tick && !ol_hit) |=> st_r.ol_cnt == 3'h0;
	endproperty
	a_ol_clear: assert property (p_ol_clear) else $error("debounce not cleared");

	property p_fault_hold;
		(open_led_fault_o && !ctrl.en_req) |=> open_led_fault_o;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault left without re-enable");

	property p_uv_off;
		uv_s |=> !switch_gate_o && !active_o;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("switch on under undervoltage");

	property p_auto_restart;
		(st_r.mode == lbc_pkg::LBC_HOLD && !uv_s && !ot_s && !ctrl.off_req) |=> active_o;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("no automatic restart");

	property p_shut_quiet;
		!active_o |-> !switch_gate_o;
	endproperty
	a_shut_quiet: assert property (p_shut_quiet) else $error("switch pulse outside run");

	property p_pulse_start;
		(active_o && tick ##1 active_o) |-> switch_gate_o;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("cycle did not start a pulse");

	property p_enable;
		(st_r.mode == lbc_pkg::LBC_SHUT && ctrl.en_req && !uv_s && !ot_s) |=> active_o;
	endproperty
	a_enable: assert property (p_enable) else $error("rising edge did not enable");

	c_start: cover property (!active_o ##1 active_o);
	c_ramp_done: cover property (active_o && st_r.step == SS_STEPS);
	c_ol_fault: cover property (active_o ##1 open_led_fault_o);
	c_hold_back: cover property (st_r.mode == lbc_pkg::LBC_HOLD ##1 active_o);
endmodule

// [test/lbc_host_model.sv]
// Purpose: host controller model driving the control pin
// Assumes: callers step on the falling clock edge
// Notes:   pin idles low, as its pull-down holds it when the host is quiet
`timescale 1ns/1ps
module lbc_host_model (
	input  wire logic clk_sys_i,
	output logic      ctrl_pin_o
);
	initial ctrl_pin_o = 1'b0;

	// drive a level, then hold it for n cycles; n of 0 just sets it
	task automatic hold(input logic lvl, input int n);
		ctrl_pin_o = lvl;
		repeat (n) @(negedge clk_sys_i);
	endtask

	// dimming wave; lows kept short of the shutdown time so it never turns off
	task automatic pwm(input int hi, input int lo, input int reps);
		repeat (reps)
		begin
			hold(1'b1, hi);
			hold(1'b0, lo);
		end
		ctrl_pin_o = 1'b1;
	endtask
endmodule

// [test/lbc_seq_tb_top.sv]
// Purpose: self-checking bench of the LED boost sequencer
// Assumes: shortened off and half-limit counts; one ramp step only, a full ramp is too long
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module lbc_seq_tb_top;
	localparam int unsigned OFF_CYC  = 50;
	localparam int unsigned HALF_CYC = 20;
	localparam int          TICK     = 42;
	localparam int          STEP     = 254;
	localparam int          MAX_ON   = 39;

	logic       clk_sys;
	logic       rst;
	logic       pin;
	logic       ovp;
	logic       fbl;
	logic       uvlo;
	logic       hot;
	logic       trip;
	logic       gate;
	logic [7:0] ref_mv;
	logic [7:0] thresh;
	logic       ilim_half;
	logic       active;
	logic       fault;
	int         num_errors = 0;
	int         checked = 0;
	int         now = 0;

	lbc_host_model u_host (
		.clk_sys_i  (clk_sys),
		.ctrl_pin_o (pin)
	);

	lbc_seq #(.OFF_CYC(OFF_CYC), .HALF_CYC(HALF_CYC)) u_dut (
		.clk_sys_i          (clk_sys),
		.reset_i            (rst),
		.ctrl_pin_i         (pin),
		.sw_ovp_i           (ovp),
		.fb_low_i           (fbl),
		.uvlo_i             (uvlo),
		.over_temp_i        (hot),
		.cur_trip_i         (trip),
		.switch_gate_o      (gate),
		.ref_mv_o           (ref_mv),
		.fb_low_thresh_mv_o (thresh),
		.ilim_half_o        (ilim_half),
		.active_o           (active),
		.open_led_fault_o   (fault)
	);

	// 50 MHz clock and a cycle count used as a time stamp
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) now++;

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic till(input int t);
		while (now < t) cyc(1);
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// reference the ramp should show: full scale times step fraction times duty fraction
	function automatic logic [7:0] exp_ref(input int step, input int duty);
		return 8'((200 * step * duty) >> 13);
	endfunction

	// high time and rise-to-rise period of the next gate pulse, bounded waits
	task automatic gate_pulse(output int w, output int p);
		int n;
		n = 0;
		w = 0;
		while (gate !== 1'b1 && n < 100)
		begin
			cyc(1);
			n++;
		end
		while (gate === 1'b1 && w < 100)
		begin
			cyc(1);
			w++;
		end
		p = w;
		while (gate !== 1'b1 && p < 100)
		begin
			cyc(1);
			p++;
		end
	endtask

	task automatic gate_quiet(input int n);
		int hi;
		hi = 0;
		repeat (n)
		begin
			cyc(1);
			if (gate !== 1'b0) hi++;
		end
		check("gate idle", 8'(hi), 8'h00);
	endtask

	// enable, pulse rate and width, half limit span, short low, first ramp step
	task automatic t_start();
		int w;
		int p;
		int t0;
		check("active", 8'(active), 8'h00);
		gate_quiet(100);
		t0 = now;
		u_host.hold(1'b1, 6);
		check("active", 8'(active), 8'h01);
		check("ilim", 8'(ilim_half), 8'h01);
		check("ref", ref_mv, 8'h00);
		gate_pulse(w, p);
		check("period", 8'(p), 8'(TICK));
		check("max on", 8'(w), 8'(MAX_ON));
		trip = 1'b1;
		gate_pulse(w, p);
		check("tripped on", 8'(w <= 4), 8'h01);
		trip = 1'b0;
		till(t0 + 780);
		check("ilim", 8'(ilim_half), 8'h01);
		till(t0 + 900);
		check("ilim", 8'(ilim_half), 8'h00);
		u_host.hold(1'b0, OFF_CYC - 10);
		u_host.hold(1'b1, 10);
		check("active", 8'(active), 8'h01);
		till(t0 + 4 + STEP * TICK - 60);
		check("ref", ref_mv, 8'h00);
		till(t0 + 4 + STEP * TICK + 100);
		check("ref", ref_mv, exp_ref(1, 256));
		check("thresh", thresh, exp_ref(1, 256) >> 1);
	endtask

	// broken debounce must not trip; a full one latches until the pin toggles
	task automatic t_open_led();
		ovp = 1'b1;
		fbl = 1'b1;
		cyc(5 * TICK);
		fbl = 1'b0;
		cyc(TICK + 10);
		fbl = 1'b1;
		cyc(6 * TICK);
		check("fault", 8'(fault), 8'h00);
		cyc(4 * TICK);
		check("fault", 8'(fault), 8'h01);
		ovp = 1'b0;
		fbl = 1'b0;
		gate_quiet(300);
		check("active", 8'(active), 8'h00);
		u_host.hold(1'b0, 10);
		u_host.hold(1'b1, 8);
		check("fault", 8'(fault), 8'h00);
		check("active", 8'(active), 8'h01);
		check("ilim", 8'(ilim_half), 8'h01);
	endtask

	// undervoltage then over-temperature; a debounce half-count must not survive
	task automatic t_hold();
		for (int k = 0; k < 2; k++)
		begin
			ovp = 1'b1;
			fbl = 1'b1;
			cyc(5 * TICK);
			uvlo = (k == 0);
			hot = (k == 1);
			cyc(5);
			check("active", 8'(active), 8'h00);
			gate_quiet(200);
			uvlo = 1'b0;
			hot = 1'b0;
			cyc(5);
			check("active", 8'(active), 8'h01);
			check("ilim", 8'(ilim_half), 8'h01);
			cyc(5 * TICK);
			check("fault", 8'(fault), 8'h00);
			ovp = 1'b0;
			fbl = 1'b0;
			cyc(TICK);
		end
	endtask

	// long low shuts down; restart under a half duty wave halves the reference
	task automatic t_off_dim();
		u_host.hold(1'b0, OFF_CYC + 20);
		check("active", 8'(active), 8'h00);
		u_host.pwm(32, 32, 169);
		check("active", 8'(active), 8'h01);
		check("ref", ref_mv, exp_ref(1, 128));
		check("thresh", thresh, exp_ref(1, 128) >> 1);
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// reset for 5 cycles, then the scenarios in turn
	initial
	begin
		rst = 1'b1;
		ovp = 1'b0;
		fbl = 1'b0;
		uvlo = 1'b0;
		hot = 1'b0;
		trip = 1'b0;
		cyc(5);
		rst = 1'b0;
		cyc(2);
		t_start();
		t_open_led();
		t_hold();
		t_off_dim();
		report_and_stop();
	end

	// scenarios take about 25k cycles; a hang is cut well past that
	initial
	begin
		cyc(60000);
		num_errors++;
		report_and_stop();
	end
endmodule
